/* File: dbgab_consts.svh */
// reset values for the debug abort discard block
`ifndef DBGAB_CONSTS_SVH
`define DBGAB_CONSTS_SVH

`define DBGAB_HALTED_RST      1'b0
`define DBGAB_DISCARD_RST     1'b0
`define DBGAB_ABORT_SEEN_RST  1'b0
`define DBGAB_PENDING_RST     1'b0

`endif

/* File: dbgab_pkg.sv */
// types for the debug abort discard block
`default_nettype none
package dbgab_pkg;

    typedef enum logic [1:0] {
        DBGAB_RUN,
        DBGAB_DRAIN,
        DBGAB_HALT
    } dbgab_state_t;

    // status bits as seen in the debug status and control register
    typedef struct packed {
        logic halted;
        logic discard;
        logic abort_seen;
        logic abort_pending;
    } dbgab_status_t;

    // requests from the core and the debugger, all on sys_clk
    typedef struct packed {
        logic halt_req;
        logic exit_req;
        logic abort_evt;
        logic abort_outstanding;
        logic abort_taken;
        logic dbg_ack;
        logic flag_clr;
    } dbgab_req_t;

endpackage : dbgab_pkg
`default_nettype wire

/* File: dbgab_discard.sv */
// debug halt entry and asynchronous data abort discard logic
// How it works
// - while discard is set, an asynchronous abort takes no exception and only sets the sticky abort-seen flag.
// - halt entry completes only once no asynchronous abort can still be outstanding.
// - discard is set in the very cycle the core enters debug halt state.
// - the debug acknowledge bit alone never sets discard outside debug halt state.
// - an abort recognized while discard is clear is made pending until the core takes it.
`timescale 1ns/1ps
`default_nettype none
`include "dbgab_consts.svh"

module dbgab_discard (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire dbgab_pkg::dbgab_req_t   req,
    output var  dbgab_pkg::dbgab_status_t status
);

    // ----------------------------------------------------------------
    // halt state machine
    // ----------------------------------------------------------------
    dbgab_pkg::dbgab_state_t state_q;
    dbgab_pkg::dbgab_state_t state_d;

    // one decode feeds both status bits so they can never disagree
    function automatic logic dbgab_is_halt(input dbgab_pkg::dbgab_state_t s);
        return (s == dbgab_pkg::DBGAB_HALT);
    endfunction : dbgab_is_halt

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dbgab_pkg::DBGAB_RUN: begin
                // halt_req outside run is dropped; the core holds it as a level if it still wants halt
                if (req.halt_req) begin
                    state_d = dbgab_pkg::DBGAB_DRAIN;
                end
            end
            dbgab_pkg::DBGAB_DRAIN: begin
                // wait out stores whose error answer may still come back
                if (!req.abort_outstanding) begin
                    state_d = dbgab_pkg::DBGAB_HALT;
                end
            end
            dbgab_pkg::DBGAB_HALT: begin
                if (req.exit_req) begin
                    state_d = dbgab_pkg::DBGAB_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= dbgab_pkg::DBGAB_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // status bits
    // ----------------------------------------------------------------
    logic halted_q;
    logic halted_d;
    logic discard_q;
    logic discard_d;
    logic abort_seen_q;
    logic abort_seen_d;
    logic pending_q;
    logic pending_d;

    always_comb begin
        halted_d = dbgab_is_halt(state_d);
        // derived from halt state only; the acknowledge bit plays no part
        // a copy of halted rather than a flop with its own set path, so no other input can reach it
        discard_d = dbgab_is_halt(state_d);
        // the abort is judged against the discard value of this cycle
        abort_seen_d = abort_seen_q;
        if (req.flag_clr) begin
            abort_seen_d = 1'b0;
        end
        if (req.abort_evt && discard_q) begin
            abort_seen_d = 1'b1;
        end
        pending_d = pending_q;
        if (req.abort_taken) begin
            pending_d = 1'b0;
        end
        // set beats the take so a back to back abort is not lost
        if (req.abort_evt && !discard_q) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            halted_q     <= `DBGAB_HALTED_RST;
            discard_q    <= `DBGAB_DISCARD_RST;
            abort_seen_q <= `DBGAB_ABORT_SEEN_RST;
            pending_q    <= `DBGAB_PENDING_RST;
        end else begin
            halted_q     <= halted_d;
            discard_q    <= discard_d;
            abort_seen_q <= abort_seen_d;
            pending_q    <= pending_d;
        end
    end

    // debugger reads abort_seen before exit; nothing here enforces it
    always_comb begin
        status.halted        = halted_q;
        status.discard       = discard_q;
        status.abort_seen    = abort_seen_q;
        status.abort_pending = pending_q;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // each set and clear is checked alone and for the cycle in which both meet

    a_drop_no_pend: assert property (
        (discard_q && req.abort_evt && !req.flag_clr)
            |=> abort_seen_q && (pending_q == ($past(pending_q) && !$past(req.abort_taken))))
        else $error("discarded abort did not set flag or touched pending");

    a_halt_drained: assert property (
        $rose(halted_q) |-> !$past(req.abort_outstanding) && ($past(state_q) == dbgab_pkg::DBGAB_DRAIN))
        else $error("halt entered with abort possibly outstanding");

    a_discard_entry: assert property (
        $rose(halted_q) |-> discard_q)
        else $error("discard not set on halt entry");

    a_ack_no_discard: assert property (
        (!halted_q && req.dbg_ack) |-> !discard_q)
        else $error("discard set outside halt");

    a_normal_pend: assert property (
        (!discard_q && req.abort_evt) |=> pending_q && (!$changed(abort_seen_q) || $past(req.flag_clr)))
        else $error("normal abort not pending or flag touched");

    a_sticky_hold: assert property (
        (abort_seen_q && !req.flag_clr) |=> abort_seen_q)
        else $error("sticky flag dropped without clear");

    a_exit_clears: assert property (
        (state_q == dbgab_pkg::DBGAB_HALT && req.exit_req) |=> !discard_q && !halted_q)
        else $error("discard held after leaving halt");

    a_halt_fast: assert property (
        (state_q == dbgab_pkg::DBGAB_RUN && req.halt_req) ##1 !req.abort_outstanding |=> halted_q)
        else $error("halt entry stalled with nothing outstanding");

    a_seen_set_wins: assert property (
        (discard_q && req.abort_evt && req.flag_clr) |=> abort_seen_q)
        else $error("clear beat a discarded abort");

    a_no_false_seen: assert property (
        (!abort_seen_q && !(discard_q && req.abort_evt)) |=> !abort_seen_q)
        else $error("sticky flag set without a discarded abort");

    a_clear_drops: assert property (
        (req.flag_clr && !(discard_q && req.abort_evt)) |=> !abort_seen_q)
        else $error("sticky flag survived its clear");

    a_pend_set_wins: assert property (
        (!discard_q && req.abort_evt && req.abort_taken) |=> pending_q)
        else $error("take beat a new abort");

    a_take_clears: assert property (
        (req.abort_taken && !(!discard_q && req.abort_evt)) |=> !pending_q)
        else $error("pending abort survived its take");

    a_pend_hold: assert property (
        (pending_q && !req.abort_taken) |=> pending_q)
        else $error("pending abort lost before it was taken");

    // discard is still clear while draining, so aborts there are normal ones
    a_drain_pends: assert property (
        (state_q == dbgab_pkg::DBGAB_DRAIN && req.abort_evt) |=> pending_q)
        else $error("abort during drain not made pending");

    a_drain_waits: assert property (
        (state_q == dbgab_pkg::DBGAB_DRAIN && req.abort_outstanding) |=> !halted_q && !discard_q)
        else $error("halt entered while an abort was outstanding");

    a_exit_in_drain: assert property (
        (state_q == dbgab_pkg::DBGAB_DRAIN && req.abort_outstanding && req.exit_req)
            |=> state_q == dbgab_pkg::DBGAB_DRAIN)
        else $error("exit request cut the drain short");

    a_run_no_leap: assert property (
        (state_q == dbgab_pkg::DBGAB_RUN) |=> !halted_q)
        else $error("halt entered without passing the drain");

    a_discard_stays: assert property (
        (halted_q && !req.exit_req) |=> halted_q && discard_q)
        else $error("discard dropped while still halted");

    a_halt_ignored: assert property (
        (state_q == dbgab_pkg::DBGAB_HALT && req.halt_req && !req.exit_req)
            |=> state_q == dbgab_pkg::DBGAB_HALT)
        else $error("halt request disturbed the halt state");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    // these only mark that the main scenarios were reached
    c_abort_in_halt: cover property (discard_q && req.abort_evt);
    c_abort_in_drain: cover property (state_q == dbgab_pkg::DBGAB_DRAIN && req.abort_evt);
    c_ack_abort_run: cover property (!halted_q && req.dbg_ack && req.abort_evt);
    c_full_visit: cover property ($rose(halted_q) ##[1:20] $fell(halted_q));
    c_clear_with_abort: cover property (req.flag_clr && req.abort_evt);

endmodule : dbgab_discard
`default_nettype wire

/* File: dbgab_debugger_model.sv */
// debugger model: reads the sticky flag before leaving halt, then clears it
`timescale 1ns/1ps
`default_nettype none
module dbgab_debugger_model (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     go,
    input  wire dbgab_pkg::dbgab_status_t status,
    output var  logic                     exit_req,
    output var  logic                     flag_clr,
    output var  logic                     seen_q
);
    // the flag is sampled at the same edge that raises exit_req; an abort in the exit cycle still sets the flag but is not in seen_q
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            exit_req <= 1'b0;
            flag_clr <= 1'b0;
            seen_q   <= 1'b0;
        end else begin
            exit_req <= go;
            flag_clr <= go & status.abort_seen;
            if (go) seen_q <= status.abort_seen;
        end
    end
endmodule : dbgab_debugger_model
`default_nettype wire

/* File: dbgab_discard_bench.sv */
// testbench for the debug abort discard block
`timescale 1ns/1ps
`default_nettype none
module dbgab_discard_bench;
    logic                     sys_clk, rst_n, halt, evt, outst, taken, ack, go;
    logic                     exit_req, flag_clr, seen_q;
    dbgab_pkg::dbgab_req_t    req;
    dbgab_pkg::dbgab_status_t st;
    int                       errors;
    int                       checked;
    assign req = '{halt, exit_req, evt, outst, taken, ack, flag_clr};
    dbgab_discard dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .status(st));
    dbgab_debugger_model dbg (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .status(st),
                              .exit_req(exit_req), .flag_clr(flag_clr), .seen_q(seen_q));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : step
    task automatic chk(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk
    task automatic pulse_abort;
        evt = 1'b1;
        step(1);
        evt = 1'b0;
    endtask : pulse_abort
    task automatic drain_then_halt;
        halt = 1'b1;
        outst = 1'b1;
        step(1);
        halt = 1'b0;
        pulse_abort();
        step(2);
        chk("halted_in_drain", st.halted, 1'b0);
        chk("pending_in_drain", st.abort_pending, 1'b1);
        outst = 1'b0;
        step(1);
        chk("halted", st.halted, 1'b1);
        chk("discard", st.discard, 1'b1);
        chk("seen_after_drain", st.abort_seen, 1'b0);
        taken = 1'b1;
        step(1);
        taken = 1'b0;
        chk("pending_taken", st.abort_pending, 1'b0);
    endtask : drain_then_halt
    task automatic abort_in_halt;
        pulse_abort();
        chk("seen_in_halt", st.abort_seen, 1'b1);
        chk("pending_in_halt", st.abort_pending, 1'b0);
        step(5);
        chk("seen_sticky", st.abort_seen, 1'b1);
        chk("discard_held", st.discard, 1'b1);
    endtask : abort_in_halt
    task automatic leave_halt;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(1);
        chk("debugger_saw_flag", seen_q, 1'b1);
        chk("halted_exit", st.halted, 1'b0);
        chk("discard_exit", st.discard, 1'b0);
        chk("seen_cleared", st.abort_seen, 1'b0);
    endtask : leave_halt
    task automatic ack_outside_halt;
        ack = 1'b1;
        step(3);
        chk("discard_ack", st.discard, 1'b0);
        pulse_abort();
        chk("pending_ack", st.abort_pending, 1'b1);
        chk("seen_ack", st.abort_seen, 1'b0);
        ack = 1'b0;
    endtask : ack_outside_halt
    task automatic set_beats_take;
        taken = 1'b1;
        evt = 1'b1;
        step(1);
        evt = 1'b0;
        chk("pending_set_wins", st.abort_pending, 1'b1);
        chk("seen_set_wins", st.abort_seen, 1'b0);
        step(1);
        taken = 1'b0;
        chk("pending_cleared", st.abort_pending, 1'b0);
    endtask : set_beats_take
    task automatic exit_refused_in_drain;
        halt = 1'b1;
        outst = 1'b1;
        step(1);
        halt = 1'b0;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(1);
        chk("exit_refused_drain", st.halted, 1'b0);
        outst = 1'b0;
        step(1);
        chk("halted_fast", st.halted, 1'b1);
        chk("discard_fast", st.discard, 1'b1);
        chk("seen_fast", st.abort_seen, 1'b0);
    endtask : exit_refused_in_drain
    task automatic reset_mid_run;
        rst_n = 1'b0;
        step(1);
        chk("halted_in_reset", st.halted, 1'b0);
        chk("discard_in_reset", st.discard, 1'b0);
        rst_n = 1'b1;
        step(2);
        chk("halted_after_reset", st.halted, 1'b0);
        chk("pending_after_reset", st.abort_pending, 1'b0);
    endtask : reset_mid_run
    task automatic test_done;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    // a hang counts as a mismatch and still reaches the report
    initial begin
        #100us;
        errors++;
        test_done();
    end
    initial begin
        {rst_n, halt, evt, outst, taken, ack, go} = 7'h00;
        errors = 0;
        checked = 0;
        step(4);
        rst_n = 1'b1;
        step(1);
        drain_then_halt();
        abort_in_halt();
        leave_halt();
        ack_outside_halt();
        set_beats_take();
        exit_refused_in_drain();
        reset_mid_run();
        test_done();
    end
endmodule : dbgab_discard_bench
`default_nettype wire
